// ===== core/optc_pkg.sv
// shared constants, register map and carrier types for the output phase/status control block
package optc_pkg;

  // structure sizes
  localparam int NUM_OUT  = 8;
  localparam int NUM_PLL  = 2;
  localparam int NUM_FLAG = 8;
  localparam int STEP_W   = 5;
  localparam int FINE_W   = 4;
  localparam int SRC_W    = 3;

  // timing: settle window after relock or resync
  localparam int CLK_PERIOD_NS = 5;
  localparam int SETTLE_NS     = 350;
  localparam int SETTLE_CYC    = (SETTLE_NS / CLK_PERIOD_NS < 1) ? 1 : SETTLE_NS / CLK_PERIOD_NS;

  // coarse adjustment figures
  localparam logic [4:0] COARSE_MAX_STEPS = 5'h1f;
  localparam logic [1:0] COARSE_GAP_LAST  = 2'h3;  // one stretch every 4 output periods

  // register byte offsets
  localparam logic [7:0] REG_CTRL     = 8'h00;
  localparam logic [7:0] REG_OUTCTL   = 8'h04;
  localparam logic [7:0] REG_SRC      = 8'h08;
  localparam logic [7:0] REG_FINE     = 8'h0c;
  localparam logic [7:0] REG_COARSE0  = 8'h10;
  localparam logic [7:0] REG_COARSE7  = 8'h2c;
  localparam logic [7:0] REG_GPIO_CFG = 8'h30;
  localparam logic [7:0] REG_GPIO_IN  = 8'h34;
  localparam logic [7:0] REG_FLAG     = 8'h38;
  localparam logic [7:0] REG_IRQ_EN   = 8'h3c;
  localparam logic [7:0] REG_LIVE     = 8'h40;

  // field positions
  localparam int F_CTRL_SHUT  = 2;
  localparam int F_OUT_INV    = 8;
  localparam int F_OUT_CINV   = 16;
  localparam int F_OUT_PD     = 24;
  localparam int F_SRC_BYP    = 24;
  localparam int F_CO_TRIG    = 8;
  localparam int F_CO_BUSY    = 9;
  localparam int F_GPIO_FIX   = 8;
  localparam int F_GPIO_GPO   = 16;
  localparam int F_FLAG_IRQ   = 8;

  // divider source select codes
  localparam logic [2:0] SRC_PLL0  = 3'h0;
  localparam logic [2:0] SRC_PLL1  = 3'h1;
  localparam logic [2:0] SRC_FRAC2 = 3'h2;
  localparam logic [2:0] SRC_FRAC3 = 3'h3;

  // pins whose fixed input function is a reference select
  localparam logic [7:0] CSEL_PIN_MASK = 8'hcc;

  localparam logic [31:0] RST_WORD = 32'h0000_0000;

  // classic wishbone request
  typedef struct packed {
    logic        cyc;
    logic        stb;
    logic        we;
    logic [3:0]  sel;
    logic [7:0]  adr;
    logic [31:0] dat;
  } optc_wb_req_t;

  // live alarm vector, also the sticky flag layout
  typedef struct packed {
    logic [3:0] ref_loss;
    logic [1:0] hold;
    logic [1:0] unlock;
  } optc_alarm_t;

endpackage : optc_pkg

// ===== core/optc_core.sv
// output phase adjustment, enable gating, gpio muxing and sticky status for the clock outputs
//
// Implementation choices: the address map and the Wishbone interface to the registers.
`timescale 1ns/10ps
`default_nettype none

module optc_core #(
  parameter int SETTLE_CYCLES = optc_pkg::SETTLE_CYC
) (
  input  wire logic                  i_clk_sys,
  input  wire logic                  i_rst_n,
  input  wire optc_pkg::optc_wb_req_t i_wb,
  output logic                       o_wb_ack,
  output logic [31:0]                o_wb_dat,
  input  wire logic [1:0]            i_pll_lock,
  input  wire logic [1:0]            i_hold_alarm,
  input  wire logic [3:0]            i_ref_loss,
  input  wire logic                  i_cfg_loaded,
  input  wire logic [7:0]            i_out_period_tick,
  input  wire logic [7:0]            i_gpio_in,
  output logic [7:0]                 o_gpio_out,
  output logic [7:0]                 o_gpio_oe,
  output logic [7:0]                 o_out_drive_en,
  output logic [7:0]                 o_out_invert,
  output logic [7:0]                 o_comp_invert,
  output logic [7:0]                 o_out_power_down,
  output logic [23:0]                o_divider_source_select,
  output logic [3:0]                 o_div_bypass,
  output logic                       o_pll1_shutdown,
  output logic [7:0]                 o_coarse_stretch,
  output logic [7:0]                 o_fine_load,
  output logic [7:0]                 o_fine_offset,
  output logic [1:0]                 o_pll0_ref_select_pin,
  output logic [1:0]                 o_pll1_ref_select_pin,
  output logic [1:0]                 o_outputs_settling,
  output logic                       o_irq_n_pin
);
  import optc_pkg::*;

  localparam int SCNT_W = $clog2(SETTLE_CYCLES + 1);

  ////////////////////////////////////////////////////////////////////////////////
  // functions

  // byte-lane merge of a wishbone write
  function automatic logic [31:0] wmerge(input logic [31:0] old, input logic [31:0] dat,
                                         input logic [3:0] sel);
    logic [31:0] r;
    r = old;
    for (int b = 0; b < 4; b++) begin
      if (sel[b]) begin
        r[8*b +: 8] = dat[8*b +: 8];
      end
    end
    return r;
  endfunction : wmerge

  // outputs whose divider is fed, directly or via a fractional divider, by a pll
  function automatic logic [7:0] pll_members(input logic [23:0] src, input logic pll);
    logic [7:0] m;
    logic [2:0] p;
    m = 8'h00;
    p = pll ? SRC_PLL1 : SRC_PLL0;
    for (int i = 0; i < NUM_OUT; i++) begin
      m[i] = (src[SRC_W*i +: SRC_W] == p)
           | ((src[SRC_W*i +: SRC_W] == SRC_FRAC2) && (src[SRC_W*2 +: SRC_W] == p))
           | ((src[SRC_W*i +: SRC_W] == SRC_FRAC3) && (src[SRC_W*3 +: SRC_W] == p));
    end
    return m;
  endfunction : pll_members

  // live status bit carried by a pin in fixed output mode
  function automatic logic gpio_status(input int pin, input logic [7:0] live);
    case (pin)
      0:       return live[0];
      1:       return live[2];
      2:       return live[4];
      3:       return live[1];
      4:       return live[3];
      5:       return live[5];
      6:       return live[6];
      default: return live[7];
    endcase
  endfunction : gpio_status

  ////////////////////////////////////////////////////////////////////////////////
  // reset release and pin synchronisers

  logic [1:0]  rst_pipe_reg;
  logic        rst_n;
  logic [16:0] sync1_reg;
  logic [16:0] sync2_reg;

  // async assert, release through two flops
  always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
    if (!i_rst_n) begin
      rst_pipe_reg <= 2'h0;
    end else begin
      rst_pipe_reg <= {rst_pipe_reg[0], 1'b1};
    end
  end
  assign rst_n = rst_pipe_reg[1];

  // every pin passes two flops before any logic reads it
  always_ff @(posedge i_clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      sync1_reg <= 17'h0_0003;  // lock bits rest high: no false unlock flag after reset
      sync2_reg <= 17'h0_0003;
    end else begin
      sync1_reg <= {i_cfg_loaded, i_gpio_in, i_ref_loss, i_hold_alarm, i_pll_lock};
      sync2_reg <= sync1_reg;
    end
  end

  logic        cfg_ok;
  logic [7:0]  pin_in;
  logic [1:0]  locked;
  optc_alarm_t alarm;

  assign locked         = sync2_reg[1:0];
  assign alarm.unlock   = ~sync2_reg[1:0];  // lock state only, settle excluded
  assign alarm.hold     = sync2_reg[3:2];
  assign alarm.ref_loss = sync2_reg[7:4];
  assign pin_in         = sync2_reg[15:8];
  assign cfg_ok         = sync2_reg[16];

  ////////////////////////////////////////////////////////////////////////////////
  // wishbone slave: one wait state, unmapped reads zero, unmapped writes dropped

  logic        acc;
  logic        wr;
  logic [31:0] wd;
  logic [2:0]  co_idx;
  logic        co_hit;
  logic [31:0] rdata;

  assign acc    = i_wb.cyc & i_wb.stb & ~o_wb_ack;
  assign wr     = acc & i_wb.we;
  assign co_hit = (i_wb.adr >= REG_COARSE0) && (i_wb.adr <= REG_COARSE7) && (i_wb.adr[1:0] == 2'h0);
  assign co_idx = 3'((i_wb.adr - REG_COARSE0) >> 2);

  logic [2:0]  ctrl_reg;
  logic [31:0] outctl_reg;
  logic [27:0] src_reg;
  logic [7:0]  fine_reg;
  logic [4:0]  steps_reg [NUM_OUT];
  logic [7:0]  trig_reg;
  logic [7:0]  busy_reg;
  logic [23:0] gpio_reg;
  logic [7:0]  flag_reg;
  logic [7:0]  ien_reg;

  // ack is a single-cycle answer, dropped the cycle after
  always_ff @(posedge i_clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      o_wb_ack <= 1'b0;
      o_wb_dat <= RST_WORD;
    end else begin
      o_wb_ack <= acc;
      o_wb_dat <= acc ? rdata : RST_WORD;
    end
  end

  // read mux
  always_comb begin
    rdata = RST_WORD;
    if (co_hit) begin
      rdata[STEP_W-1:0]  = steps_reg[co_idx];
      rdata[F_CO_TRIG]   = trig_reg[co_idx];
      rdata[F_CO_BUSY]   = busy_reg[co_idx];
    end else begin
      case (i_wb.adr)
        REG_CTRL:     rdata[2:0]  = ctrl_reg;
        REG_OUTCTL:   rdata       = outctl_reg;
        REG_SRC:      rdata[27:0] = src_reg;
        REG_FINE:     rdata[7:0]  = fine_reg;
        REG_GPIO_CFG: rdata[23:0] = gpio_reg;
        REG_GPIO_IN:  rdata[7:0]  = pin_in;                   // general_input_bit
        REG_FLAG:     rdata[8:0]  = {|(flag_reg & ien_reg), flag_reg};
        REG_IRQ_EN:   rdata[7:0]  = ien_reg;
        REG_LIVE:     rdata[7:0]  = alarm;
        default:      rdata       = RST_WORD;
      endcase
    end
  end

  // configuration registers
  always_ff @(posedge i_clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      ctrl_reg   <= 3'h0;
      outctl_reg <= RST_WORD;
      src_reg    <= 28'h000_0000;
      fine_reg   <= 8'h00;
      gpio_reg   <= 24'h00_0000;
      ien_reg    <= 8'h00;
    end else if (wr) begin
      case (i_wb.adr)
        REG_CTRL:     ctrl_reg   <= 3'(wmerge({29'h0, ctrl_reg}, i_wb.dat, i_wb.sel));
        REG_OUTCTL:   outctl_reg <= wmerge(outctl_reg, i_wb.dat, i_wb.sel);
        REG_SRC:      src_reg    <= 28'(wmerge({4'h0, src_reg}, i_wb.dat, i_wb.sel));
        REG_FINE:     fine_reg   <= 8'(wmerge({24'h0, fine_reg}, i_wb.dat, i_wb.sel));
        REG_GPIO_CFG: gpio_reg   <= 24'(wmerge({8'h0, gpio_reg}, i_wb.dat, i_wb.sel));
        REG_IRQ_EN:   ien_reg    <= 8'(wmerge({24'h0, ien_reg}, i_wb.dat, i_wb.sel));
        default:      ctrl_reg   <= ctrl_reg;
      endcase
    end
  end

  // current coarse word with the write's byte lanes merged in
  assign wd = wmerge({23'h0, trig_reg[co_idx], 3'h0, steps_reg[co_idx]}, i_wb.dat, i_wb.sel);

  // coarse request: step count and trigger toggle per output
  always_ff @(posedge i_clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      for (int i = 0; i < NUM_OUT; i++) begin
        steps_reg[i] <= 5'h00;
      end
      trig_reg <= 8'h00;
    end else if (wr && co_hit) begin
      steps_reg[co_idx] <= wd[STEP_W-1:0];                     // up to 31 steps
      trig_reg[co_idx]  <= wd[F_CO_TRIG];
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // resync events per pll

  logic [7:0] member [NUM_PLL];
  logic [1:0] lock_d_reg;
  logic [1:0] tog_d_reg;
  logic [1:0] evt;
  logic [7:0] clr;
  logic [7:0] load;
  logic [3:0] bypass;

  assign member[0] = pll_members(src_reg[23:0], 1'b0);
  assign member[1] = pll_members(src_reg[23:0], 1'b1);
  assign bypass    = src_reg[F_SRC_BYP +: 4];

  // relock or a flipped resync bit both resync the pll's outputs
  assign evt  = (locked & ~lock_d_reg) | (ctrl_reg[1:0] ^ tog_d_reg);
  // coarse cleared while unlocked, on resync, and on power-down
  assign clr  = (member[0] & {8{evt[0] | ~locked[0]}})
              | (member[1] & {8{evt[1] | ~locked[1]}})
              | outctl_reg[F_OUT_PD +: 8];
  assign load = (member[0] & {8{evt[0]}}) | (member[1] & {8{evt[1]}});

  always_ff @(posedge i_clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      lock_d_reg <= 2'h3;  // matches the resting lock level, so no false relock
      tog_d_reg  <= 2'h0;
    end else begin
      lock_d_reg <= locked;
      tog_d_reg  <= ctrl_reg[1:0];
    end
  end

  // fine reload; fractional outputs jump straight to the new offset, phase otherwise free
  always_ff @(posedge i_clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      o_fine_load   <= 8'h00;
      o_fine_offset <= 8'h00;
    end else begin
      o_fine_load <= load;
      if (load[2]) begin
        o_fine_offset[FINE_W-1:0] <= fine_reg[FINE_W-1:0];
      end
      if (load[3]) begin
        o_fine_offset[FINE_W +: FINE_W] <= fine_reg[FINE_W +: FINE_W];
      end
    end
  end

  // settle window; kept apart from the unlock status on purpose
  logic [SCNT_W-1:0] scnt_reg [NUM_PLL];

  always_ff @(posedge i_clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      scnt_reg[0]        <= '0;
      scnt_reg[1]        <= '0;
      o_outputs_settling <= 2'h0;
    end else begin
      for (int p = 0; p < NUM_PLL; p++) begin
        if (evt[p]) begin
          scnt_reg[p] <= SCNT_W'(SETTLE_CYCLES);
        end else if (scnt_reg[p] != '0) begin
          scnt_reg[p] <= scnt_reg[p] - SCNT_W'(1);
        end
        o_outputs_settling[p] <= evt[p] | (scnt_reg[p] > SCNT_W'(1));
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // coarse engine: stretch one period per tick, then skip three output periods

  logic [4:0] remain_reg [NUM_OUT];
  logic [1:0] gap_reg    [NUM_OUT];
  logic [7:0] trig_d_reg;
  logic [7:0] start;
  logic [7:0] byp_out;

  // only outputs 4..7 have a bypassable first stage
  assign byp_out = {bypass, 4'h0};

  // a toggle while busy is dropped, software must wait for busy low
  always_comb begin
    for (int i = 0; i < NUM_OUT; i++) begin
      start[i] = (trig_reg[i] ^ trig_d_reg[i]) & ~busy_reg[i] & ~clr[i]
               & ~byp_out[i];                                  // bypassed stage: no coarse
    end
  end

  always_ff @(posedge i_clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      trig_d_reg       <= 8'h00;
      busy_reg         <= 8'h00;
      o_coarse_stretch <= 8'h00;
      for (int i = 0; i < NUM_OUT; i++) begin
        remain_reg[i] <= 5'h00;
        gap_reg[i]    <= 2'h0;
      end
    end else begin
      trig_d_reg <= trig_reg;
      for (int i = 0; i < NUM_OUT; i++) begin
        o_coarse_stretch[i] <= 1'b0;
        if (clr[i]) begin
          busy_reg[i]   <= 1'b0;
          remain_reg[i] <= 5'h00;
          gap_reg[i]    <= 2'h0;
        end else if (start[i]) begin
          busy_reg[i]   <= (steps_reg[i] != 5'h00);
          remain_reg[i] <= steps_reg[i];
          gap_reg[i]    <= 2'h0;
        end else if (busy_reg[i] && i_out_period_tick[i]) begin
          if (gap_reg[i] == 2'h0) begin
            o_coarse_stretch[i] <= 1'b1;                       // one source period longer
            remain_reg[i]       <= remain_reg[i] - 5'h01;
            gap_reg[i]          <= COARSE_GAP_LAST;
            busy_reg[i]         <= (remain_reg[i] != 5'h01);
          end else begin
            gap_reg[i] <= gap_reg[i] - 2'h1;
          end
        end
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // pins: gpio mux, output enable gating, output controls

  logic [7:0] pin_oe;
  logic [7:0] fix_in;

  // before configuration every pin is the enable of its own output
  assign fix_in = ~gpio_reg[7:0] & gpio_reg[F_GPIO_FIX +: 8];
  always_comb begin
    for (int i = 0; i < NUM_OUT; i++) begin
      if (!cfg_ok) begin
        pin_oe[i] = pin_in[i];
      end else if (fix_in[i] && !CSEL_PIN_MASK[i]) begin
        pin_oe[i] = pin_in[i];
      end else begin
        pin_oe[i] = 1'b1;
      end
    end
  end

  always_ff @(posedge i_clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      o_gpio_out            <= 8'h00;
      o_gpio_oe             <= 8'h00;
      o_pll0_ref_select_pin <= 2'h0;
      o_pll1_ref_select_pin <= 2'h0;
    end else begin
      for (int i = 0; i < NUM_OUT; i++) begin
        o_gpio_oe[i]  <= cfg_ok & gpio_reg[i];
        o_gpio_out[i] <= gpio_reg[F_GPIO_FIX + i] ? gpio_status(i, alarm)
                                                  : gpio_reg[F_GPIO_GPO + i];
      end
      // fixed-input pins 2/6 and 3/7 select references
      o_pll0_ref_select_pin <= cfg_ok ? ({pin_in[6], pin_in[2]} & {fix_in[6], fix_in[2]})
                                      : 2'h0;
      o_pll1_ref_select_pin <= cfg_ok ? ({pin_in[7], pin_in[3]} & {fix_in[7], fix_in[3]})
                                      : 2'h0;
    end
  end

  // output drive gating and static controls
  always_ff @(posedge i_clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      o_out_drive_en          <= 8'h00;
      o_out_invert            <= 8'h00;
      o_comp_invert           <= 8'h00;
      o_out_power_down        <= 8'h00;
      o_divider_source_select <= 24'h00_0000;
      o_div_bypass            <= 4'h0;
      o_pll1_shutdown         <= 1'b0;
    end else begin
      o_out_drive_en <= outctl_reg[7:0] & pin_oe & ~outctl_reg[F_OUT_PD +: 8]
                      & ~(member[1] & {8{ctrl_reg[F_CTRL_SHUT]}});
      o_out_invert            <= outctl_reg[F_OUT_INV +: 8];
      o_comp_invert           <= outctl_reg[F_OUT_CINV +: 8];
      o_out_power_down        <= outctl_reg[F_OUT_PD +: 8];
      o_divider_source_select <= src_reg[23:0];
      o_div_bypass            <= bypass;
      o_pll1_shutdown         <= ctrl_reg[F_CTRL_SHUT];
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // sticky status flags and interrupt pin

  logic [7:0] w1c;
  assign w1c = (wr && (i_wb.adr == REG_FLAG) && i_wb.sel[0]) ? i_wb.dat[7:0] : 8'h00;

  // a live alarm wins over the write-one clear
  always_ff @(posedge i_clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      flag_reg    <= 8'h00;
      o_irq_n_pin <= 1'b1;
    end else begin
      flag_reg    <= alarm | (flag_reg & ~w1c);
      o_irq_n_pin <= ~|(flag_reg & ien_reg);
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // checks

  default clocking cb @(posedge i_clk_sys);
  endclocking
  default disable iff (!rst_n);

  sequence s_relock0;
    !locked[0] ##1 locked[0];
  endsequence

  sequence s_stretch0;
    o_coarse_stretch[0] ##1 !o_coarse_stretch[0];
  endsequence

  chk_irq_pin_low: assert property ((|(flag_reg & ien_reg)) |=> !o_irq_n_pin)
    else $error("irq pin not asserted for enabled flag");
  chk_flag_set_alarm: assert property ((|alarm) |=> ((flag_reg & $past(alarm)) == $past(alarm)))
    else $error("alarm did not set its flag");
  chk_flag_sticky: assert property ((flag_reg[0] && !$past(w1c[0])) |-> $past(flag_reg[0]) || $past(alarm[0]))
    else $error("flag changed without cause");
  chk_drive_gate: assert property ((o_out_drive_en & ~$past(outctl_reg[7:0])) == 8'h00)
    else $error("output driven without register enable");
  chk_stretch_busy: assert property (s_stretch0 |-> $past(busy_reg[0], 2))
    else $error("stretch outside busy period");
  chk_bypass_no_coarse: assert property ((bypass & busy_reg[7:4] & ~$past(busy_reg[7:4])
                                          & $past(bypass)) == 4'h0)
    else $error("coarse started on bypassed divider");
  chk_unlock_clears: assert property (!locked[0] |=> ((busy_reg & $past(member[0])) == 8'h00))
    else $error("coarse busy survived unlock");
  chk_relock_reload: assert property (s_relock0 |=> ((o_fine_load & $past(member[0])) == $past(member[0])))
    else $error("fine offsets not reloaded on relock");
  chk_settle_hold: assert property ($rose(o_outputs_settling[0]) |-> o_outputs_settling[0] [*8])
    else $error("settle window too short");
  chk_unconfig_pins: assert property (!cfg_ok |=> (o_gpio_oe == 8'h00))
    else $error("pin driven before configuration");
  chk_ack_single: assert property (o_wb_ack |=> !o_wb_ack)
    else $error("ack held longer than one cycle");

endmodule : optc_core

`default_nettype wire

// ===== tb/optc_board.sv
// board-side model: drives the pin enable levels and resolves pins the block drives
`timescale 1ns/10ps
`default_nettype none
module optc_board (
  input  wire logic [7:0] i_oe_req,
  input  wire logic [7:0] i_gpio_out,
  input  wire logic [7:0] i_gpio_oe,
  output logic      [7:0] o_pin
);
  // board only drives where the block leaves the pin free, so no contention
  always_comb begin
    for (int i = 0; i < 8; i++) begin
      o_pin[i] = i_gpio_oe[i] ? i_gpio_out[i] : i_oe_req[i];
    end
  end
endmodule : optc_board
`default_nettype wire

// ===== tb/optc_core_bench.sv
// self-checking bench for the output phase and status control block
`timescale 1ns/10ps
`default_nettype none
module optc_core_bench;
  import optc_pkg::*;
  logic         clk_sys, rst_n, cfg_loaded, wb_ack, irq_n;
  optc_wb_req_t wb_req;
  logic [31:0]  wb_dat, exp_q[$];
  logic [1:0]   pll_lock, hold_alarm;
  logic [3:0]   ref_loss;
  logic [7:0]   tick, pins, oe_req, general_output_bit, gpoe, drive_en, stretch, fine_load, fine_off;
  int           num_errors, samples_checked, n_str, n_load, l0;

  optc_core #(.SETTLE_CYCLES(10)) i_optc_core (.i_clk_sys(clk_sys), .i_rst_n(rst_n),
    .i_wb(wb_req), .o_wb_ack(wb_ack), .o_wb_dat(wb_dat), .i_pll_lock(pll_lock),
    .i_hold_alarm(hold_alarm), .i_ref_loss(ref_loss), .i_cfg_loaded(cfg_loaded),
    .i_out_period_tick(tick), .i_gpio_in(pins), .o_gpio_out(general_output_bit), .o_gpio_oe(gpoe),
    .o_out_drive_en(drive_en), .o_out_invert(), .o_comp_invert(), .o_out_power_down(),
    .o_divider_source_select(), .o_div_bypass(), .o_pll1_shutdown(),
    .o_coarse_stretch(stretch), .o_fine_load(fine_load), .o_fine_offset(fine_off),
    .o_pll0_ref_select_pin(), .o_pll1_ref_select_pin(), .o_outputs_settling(),
    .o_irq_n_pin(irq_n));
  optc_board i_optc_board (.i_oe_req(oe_req), .i_gpio_out(general_output_bit), .i_gpio_oe(gpoe), .o_pin(pins));

  ////////////////////////////////////////////////////////////////////////////////
  // clock, event counters and the read-data monitor
  initial begin
    clk_sys = 1'b0;
    forever #2.5 clk_sys = ~clk_sys;
  end
  // reads ack in order, so the oldest note always matches the current ack
  always @(posedge clk_sys) begin
    if (stretch[0] === 1'b1) n_str++;
    if (fine_load[0] === 1'b1) n_load++;
    if (wb_ack === 1'b1 && wb_req.we === 1'b0 && exp_q.size() > 0) begin
      samples_checked++;
      if (wb_dat !== exp_q[0]) begin
        $display("CHECK FAILED at %0t: read %h expected %h", $time, wb_dat, exp_q[0]);
        num_errors++;
      end
      exp_q.delete(0);
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // bus and compare tasks; a read passes its expected word in dat
  task automatic wb(input logic we, input logic [7:0] adr, input logic [31:0] dat);
    if (!we) exp_q.push_back(dat);
    wb_req <= '{cyc: 1'b1, stb: 1'b1, we: we, sel: 4'hf, adr: adr, dat: dat};
    do @(posedge clk_sys); while (wb_ack !== 1'b1);
    wb_req.cyc <= 1'b0;
    wb_req.stb <= 1'b0;
    @(posedge clk_sys);
  endtask : wb
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp) begin
      $display("CHECK FAILED at %0t: pin %h expected %h", $time, got, exp);
      num_errors++;
    end
  endtask : chk
  task automatic final_report;
    $display("errors %0d checks %0d", num_errors, samples_checked);
    if (num_errors == 0 && samples_checked > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask : final_report

  ////////////////////////////////////////////////////////////////////////////////
  // main sequence
  initial begin
    num_errors = 0; samples_checked = 0; n_str = 0; n_load = 0; l0 = 0;
    rst_n = 1'b0; wb_req = '0; pll_lock = 2'b11; hold_alarm = 2'b00; ref_loss = 4'h0;
    cfg_loaded = 1'b0; tick = 8'h00; oe_req = 8'h00;
    void'($urandom(32'h6e34));
    repeat (20) @(posedge clk_sys);
    rst_n <= 1'b1;
    repeat (4) @(posedge clk_sys);
    chk(32'(irq_n), 32'h1);
    wb(1'b0, REG_FLAG, 32'h0);
    wb(1'b0, REG_IRQ_EN, 32'h0);
    oe_req <= 8'($urandom);
    wb(1'b1, REG_OUTCTL, 32'h0000_00ff);
    repeat (5) @(posedge clk_sys);
    chk(32'(drive_en), 32'(oe_req));
    // a short alarm pulse must leave its flag behind
    ref_loss <= 4'h1;
    repeat (5) @(posedge clk_sys);
    ref_loss <= 4'h0;
    repeat (5) @(posedge clk_sys);
    wb(1'b0, REG_FLAG, 32'h0000_0010);
    wb(1'b1, REG_IRQ_EN, 32'h0000_0010);
    repeat (3) @(posedge clk_sys);
    chk(32'(irq_n), 32'h0);
    ref_loss <= 4'h1;
    repeat (5) @(posedge clk_sys);
    wb(1'b1, REG_FLAG, 32'h0000_0010);
    wb(1'b0, REG_FLAG, 32'h0000_0110);
    ref_loss <= 4'h0;
    repeat (5) @(posedge clk_sys);
    wb(1'b1, REG_FLAG, 32'h0000_0010);
    wb(1'b0, REG_FLAG, 32'h0000_0000);
    repeat (3) @(posedge clk_sys);
    chk(32'(irq_n), 32'h1);
    wb(1'b1, REG_FINE, 32'h0000_005a);
    // two coarse steps: stretches on output periods 1 and 5 only
    wb(1'b1, REG_COARSE0, 32'h0000_0102);
    wb(1'b0, REG_COARSE0, 32'h0000_0302);
    for (int k = 1; k <= 8; k++) begin
      tick <= 8'h01;
      @(posedge clk_sys);
      tick <= 8'h00;
      repeat (2) @(posedge clk_sys);
      if (k == 4) chk(32'(n_str), 32'h1);
    end
    chk(32'(n_str), 32'h2);
    wb(1'b0, REG_COARSE0, 32'h0000_0102);
    l0 = n_load;
    wb(1'b1, REG_CTRL, 32'h0000_0001);
    repeat (8) @(posedge clk_sys);
    chk(32'(n_load - l0), 32'h1);
    chk(32'(fine_off), 32'h5a);
    // unlock clears a running coarse request, relock reloads fine offsets
    cfg_loaded <= 1'b1;
    wb(1'b1, REG_GPIO_CFG, 32'h0000_0101);
    wb(1'b1, REG_COARSE0, 32'h0000_0005);
    wb(1'b0, REG_COARSE0, 32'h0000_0205);
    pll_lock <= 2'b10;
    repeat (5) @(posedge clk_sys);
    wb(1'b0, REG_COARSE0, 32'h0000_0005);
    wb(1'b0, REG_FLAG, 32'h0000_0001);
    chk(32'(pins[0]), 32'h1);
    l0 = n_load;
    pll_lock <= 2'b11;
    repeat (8) @(posedge clk_sys);
    chk(32'(n_load - l0), 32'h1);
    chk(32'(pins[0]), 32'h0);
    wb(1'b0, 8'h80, 32'h0);
    final_report;
  end
  // watchdog sized well past the sequence above
  initial begin
    repeat (5000) @(posedge clk_sys);
    num_errors++;
    $display("CHECK FAILED at %0t: watchdog expired", $time);
    final_report;
  end
endmodule : optc_core_bench
`default_nettype wire
